// ==== rtl/pwdm_edge_sync.sv ====
// Purpose: synchronise the demodulator input pin and find its edges
// Assumes: pin is asynchronous to clk_sys
// Notes:   edge pulses last one clk_sys cycle
`timescale 1ns/1ps
`default_nettype none
module pwdm_edge_sync (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic clk_en,
	// pin and edges
	input  wire logic pin_in,
	output logic      rise_pulse,
	output logic      fall_pulse
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// first flop feeds only the second
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else if (clk_en) begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			last_q <= 1'b0;
		end else if (clk_en) begin
			last_q <= sync_q;
		end
	end

	assign rise_pulse = clk_en & sync_q & ~last_q;
	assign fall_pulse = clk_en & ~sync_q & last_q;
endmodule
`default_nettype wire

// ==== rtl/pwdm_pkg.sv ====
// Purpose: shared constants of the pulse width demodulator
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   offsets are byte addresses
package pwdm_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_BYTE_CTRL   = 8'h00;
	localparam logic [7:0] OFS_SHARED_CTRL = 8'h04;
	localparam logic [7:0] OFS_WIDE_CTRL   = 8'h08;
	localparam logic [7:0] OFS_LOW_LOAD    = 8'h0C;
	localparam logic [7:0] OFS_HIGH_LOAD   = 8'h10;
	localparam logic [7:0] OFS_RISE_CAP    = 8'h14;
	localparam logic [7:0] OFS_FALL_CAP    = 8'h18;
	localparam logic [7:0] OFS_COUNT       = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT    = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h24;

	// byte_timer_control fields
	localparam int BC_ENABLE      = 7;
	localparam int BC_TIMEOUT     = 5;
	localparam int BC_PRESC_HI    = 4;
	localparam int BC_PRESC_LO    = 3;
	localparam int BC_EDGE_IE     = 2;
	localparam int BC_TIMEOUT_IE  = 1;
	localparam int BC_ROUTE       = 0;

	// shared_timer_control fields
	localparam int SC_SEL_HI      = 5;
	localparam int SC_SEL_LO      = 4;
	localparam int SC_RISE_FLAG   = 1;
	localparam int SC_FALL_FLAG   = 0;

	// wide_timer_control fields
	localparam int WC_ROUTE       = 0;

	// status / mask layout
	localparam int ST_RISE        = 0;
	localparam int ST_FALL        = 1;
	localparam int ST_TIMEOUT     = 2;
	localparam int ST_WIDTH       = 3;

	// edge select and port3 bit6 source codes
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_RISE = 2'h1;
	localparam logic [1:0] SEL_FALL = 2'h2;
	localparam logic [1:0] SEL_BOTH = 2'h3;

	// values after reset
	localparam logic [7:0] LOAD_RESET  = 8'hFF;
	localparam logic [7:0] COUNT_ALL1  = 8'hFF;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [2:0] MASK_RESET  = 3'h0;
	localparam logic [2:0] PRESC_RESET = 3'h0;

	// ahb-lite codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	typedef enum logic {PWDM_WAIT_EDGE, PWDM_COUNTING} pwdm_state_e;

endpackage

// ==== rtl/pwdm_top.sv ====
// Purpose: eight-bit down counter measuring pulse widths between edges
// Assumes: AHB-Lite slave, zero wait states, word accesses only
// Notes:   counter ticks come from a prescaler of clk_sys
//
// Contract
// - counting starts at first selected edge
// - next edge captures complemented present count
// - rising to rise register, falling to fall
// - capture sets edge flag, optional interrupt
// - after capture reload all-ones, keep counting
// - count reaching zero sets timeout flag
// - after timeout counting continues from all-ones
// - wrap from zero is no timeout
// - stop and clear act one tick later
// - timer outputs routed to three port pins
`timescale 1ns/1ps
`default_nettype none
module pwdm_top
	import pwdm_pkg::*;
#(
	parameter int PRESC_W = 3
) (
	// clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// demodulator input and wide timer output
	input  wire logic        demod_pin,
	input  wire logic        sixteen_bit_timer_out,
	// port pins and interrupt
	output logic             port3_bit4_pin,
	output logic             port3_bit5_pin,
	output logic             port3_bit6_pin,
	output logic             irq
);
	import pwdm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [7:0]          byte_ctrl_q;
	logic [7:0]          shared_ctrl_q;
	logic [7:0]          wide_ctrl_q;
	logic [7:0]          low_load_value_q;
	logic [7:0]          high_load_value_q;
	logic [7:0]          rise_capture_reg_q;
	logic [7:0]          fall_capture_reg_q;
	logic [7:0]          count_q;
	logic [ST_WIDTH-1:0] flags_q;
	logic [ST_WIDTH-1:0] clr_pend_q;
	logic [ST_WIDTH-1:0] mask_q;
	logic [ST_WIDTH-1:0] set_ev;
	logic [PRESC_W-1:0]  presc_q;
	logic                run_q;
	logic                byte_timer_output_q;
	pwdm_state_e         state_q;
	logic                tick;
	logic                rise_ev;
	logic                fall_ev;
	logic                edge_hit;
	logic                ap_valid;
	logic                wr_q;
	logic [7:0]          waddr_q;
	logic                wr_now;
	logic [31:0]         rd_d;
	logic [ST_WIDTH-1:0] wr_clr;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// mask of prescaler bits that must be all ones for a tick
	function automatic logic [PRESC_W-1:0] div_mask(input logic [1:0] sel);
		logic [PRESC_W:0] one_hot;
		one_hot = '0;
		one_hot[sel] = 1'b1;
		return PRESC_W'(one_hot - 1'b1);
	endfunction

	function automatic logic [31:0] word8(input logic [7:0] v);
		return {24'h000000, v};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// input pin

	pwdm_edge_sync u_sync (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.clk_en     (clk_en),
		.pin_in     (demod_pin),
		.rise_pulse (rise_ev),
		.fall_pulse (fall_ev)
	);

	// qualifying edge per edge-select field
	always_comb begin
		unique case (shared_ctrl_q[SC_SEL_HI:SC_SEL_LO])
			SEL_NONE: edge_hit = 1'b0;
			SEL_RISE: edge_hit = rise_ev;
			SEL_FALL: edge_hit = fall_ev;
			SEL_BOTH: edge_hit = rise_ev | fall_ev;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// counter clock

	assign tick = clk_en & (&(presc_q | ~div_mask(byte_ctrl_q[BC_PRESC_HI:BC_PRESC_LO])));

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			presc_q <= PRESC_W'(PRESC_RESET);
		end else if (clk_en) begin
			presc_q <= presc_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ahb-lite slave

	assign ap_valid  = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_now    = clk_en & wr_q;

	// address phase captured, write done in data phase
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wr_q    <= 1'b0;
			waddr_q <= 8'h00;
		end else if (clk_en) begin
			wr_q    <= ap_valid & hwrite;
			waddr_q <= haddr[7:0];
		end
	end

	// read word built in address phase so hrdata is a flop
	always_comb begin
		rd_d = 32'h00000000;
		unique case (haddr[7:0])
			OFS_BYTE_CTRL:   rd_d = word8({byte_ctrl_q[7:6], flags_q[ST_TIMEOUT], byte_ctrl_q[4:0]});
			OFS_SHARED_CTRL: rd_d = word8({shared_ctrl_q[7:2], flags_q[ST_RISE], flags_q[ST_FALL]});
			OFS_WIDE_CTRL:   rd_d = word8(wide_ctrl_q);
			OFS_LOW_LOAD:    rd_d = word8(low_load_value_q);
			OFS_HIGH_LOAD:   rd_d = word8(high_load_value_q);
			OFS_RISE_CAP:    rd_d = word8(rise_capture_reg_q);
			OFS_FALL_CAP:    rd_d = word8(fall_capture_reg_q);
			OFS_COUNT:       rd_d = word8(count_q);
			OFS_IRQ_STAT:    rd_d = {29'h00000000, flags_q};
			OFS_IRQ_MASK:    rd_d = {29'h00000000, mask_q};
			default:         rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			hrdata <= 32'h00000000;
		end else if (clk_en && ap_valid && !hwrite) begin
			hrdata <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			byte_ctrl_q   <= CTRL_RESET;
			shared_ctrl_q <= CTRL_RESET;
			wide_ctrl_q   <= CTRL_RESET;
			mask_q        <= MASK_RESET;
		end else if (wr_now) begin
			unique case (waddr_q)
				OFS_BYTE_CTRL:   byte_ctrl_q   <= hwdata[7:0];
				OFS_SHARED_CTRL: shared_ctrl_q <= hwdata[7:0];
				OFS_WIDE_CTRL:   wide_ctrl_q   <= hwdata[7:0];
				OFS_IRQ_MASK:    mask_q        <= hwdata[ST_WIDTH-1:0];
				default:         ;
			endcase
		end
	end

	// load values only stored; the counter reloads all-ones itself
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			low_load_value_q  <= LOAD_RESET;
			high_load_value_q <= LOAD_RESET;
		end else if (wr_now) begin
			if (waddr_q == OFS_LOW_LOAD) begin
				low_load_value_q <= hwdata[7:0];
			end
			if (waddr_q == OFS_HIGH_LOAD) begin
				high_load_value_q <= hwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// delayed stop and flag clear

	// write-one-to-clear from status and from control status bits
	always_comb begin
		wr_clr = '0;
		if (wr_now) begin
			unique case (waddr_q)
				OFS_IRQ_STAT:    wr_clr = hwdata[ST_WIDTH-1:0];
				OFS_BYTE_CTRL:   wr_clr[ST_TIMEOUT] = hwdata[BC_TIMEOUT];
				OFS_SHARED_CTRL: begin
					wr_clr[ST_RISE] = hwdata[SC_RISE_FLAG];
					wr_clr[ST_FALL] = hwdata[SC_FALL_FLAG];
				end
				default:         wr_clr = '0;
			endcase
		end
	end

	// stop and start wait for the next counter tick
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			run_q <= 1'b0;
		end else if (tick) begin
			run_q <= byte_ctrl_q[BC_ENABLE];
		end
	end

	// clears wait for the next tick, so clearing in the same write
	// as the stop could race a timeout still in flight
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			clr_pend_q <= '0;
		end else if (clk_en) begin
			if (tick) begin
				clr_pend_q <= wr_clr;
			end else begin
				clr_pend_q <= clr_pend_q | wr_clr;
			end
		end
	end

	// set wins over a clear landing in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			flags_q <= '0;
		end else if (clk_en) begin
			if (tick) begin
				flags_q <= (flags_q & ~clr_pend_q) | set_ev;
			end else begin
				flags_q <= flags_q | set_ev;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// demodulation counter

	always_comb begin
		set_ev = '0;
		if (clk_en && run_q && state_q == PWDM_COUNTING) begin
			if (edge_hit) begin
				set_ev[ST_RISE] = rise_ev;
				set_ev[ST_FALL] = fall_ev;
			end else if (tick && count_q == 8'h01) begin
				set_ev[ST_TIMEOUT] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_q <= PWDM_WAIT_EDGE;
			count_q <= COUNT_ALL1;
		end else if (clk_en) begin
			if (!run_q) begin
				state_q <= PWDM_WAIT_EDGE;
				count_q <= COUNT_ALL1;
			end else begin
				unique case (state_q)
					PWDM_WAIT_EDGE: begin
						if (edge_hit) begin
							state_q <= PWDM_COUNTING;
							count_q <= COUNT_ALL1;
						end
					end
					PWDM_COUNTING: begin
						if (edge_hit) begin
							count_q <= COUNT_ALL1;
						end else if (tick) begin
							if (count_q == 8'h00) begin
								count_q <= COUNT_ALL1;
							end else begin
								count_q <= count_q - 8'h01;
							end
						end
					end
				endcase
			end
		end
	end

	// capture complemented count by edge direction
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rise_capture_reg_q <= 8'h00;
			fall_capture_reg_q <= 8'h00;
		end else if (clk_en && run_q && state_q == PWDM_COUNTING && edge_hit) begin
			if (rise_ev) begin
				rise_capture_reg_q <= ~count_q;
			end
			if (fall_ev) begin
				fall_capture_reg_q <= ~count_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// byte timer output toggles on every timeout
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			byte_timer_output_q <= 1'b0;
		end else if (set_ev[ST_TIMEOUT]) begin
			byte_timer_output_q <= ~byte_timer_output_q;
		end
	end

	// edge-select field doubles as bit6 source select
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			port3_bit4_pin <= 1'b0;
			port3_bit5_pin <= 1'b0;
			port3_bit6_pin <= 1'b0;
		end else if (clk_en) begin
			port3_bit4_pin <= byte_ctrl_q[BC_ROUTE] & byte_timer_output_q;
			port3_bit5_pin <= wide_ctrl_q[WC_ROUTE] & sixteen_bit_timer_out;
			unique case (shared_ctrl_q[SC_SEL_HI:SC_SEL_LO])
				SEL_NONE: port3_bit6_pin <= 1'b0;
				SEL_RISE: port3_bit6_pin <= byte_timer_output_q;
				SEL_FALL: port3_bit6_pin <= sixteen_bit_timer_out;
				SEL_BOTH: port3_bit6_pin <= byte_timer_output_q ^ sixteen_bit_timer_out;
			endcase
		end
	end

	// enables and mask bits both gate each source, then all or onto the line
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(mask_q & flags_q & {byte_ctrl_q[BC_TIMEOUT_IE],
				byte_ctrl_q[BC_EDGE_IE], byte_ctrl_q[BC_EDGE_IE]});
		end
	end

endmodule
`default_nettype wire

// ==== tb/pulse_width_demodulator_tb.sv ====
// Purpose: self-checking bench for pwdm_top
// Assumes: prescale 0, one tick per clk_sys, until the last test
// Notes:   edges k clk apart capture as k-1 mod 256
`timescale 1ns/1ps
`default_nettype none
module pulse_width_demodulator_tb;
	import pwdm_pkg::*;
	logic        clk_sys;
	logic        rstn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic        clk_en;
	logic [31:0] hwdata;
	wire         hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	wire         demod_pin;
	logic        sixteen_bit_timer_out;
	logic        port3_bit4_pin;
	logic        port3_bit5_pin;
	logic        port3_bit6_pin;
	logic        irq;
	logic [31:0] seed;
	logic [31:0] r;
	logic [31:0] c1;
	logic [7:0]  capv [2];
	logic [1:0]  fl;
	logic [1:0]  s;
	logic        started;
	logic        p4a;
	int          fail_count;
	int          total_checks;
	int          cyc;
	int          last;
	localparam logic [7:0] RA [11] = '{OFS_BYTE_CTRL, OFS_SHARED_CTRL, OFS_WIDE_CTRL, OFS_LOW_LOAD,
		OFS_HIGH_LOAD, OFS_RISE_CAP, OFS_FALL_CAP, OFS_COUNT, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h28};
	localparam logic [7:0] RV [11] = '{CTRL_RESET, CTRL_RESET, CTRL_RESET, LOAD_RESET, LOAD_RESET,
		8'h00, 8'h00, COUNT_ALL1, 8'h00, 8'h00, 8'h00};
	localparam logic [1:0] SELS [4] = '{SEL_RISE, SEL_FALL, SEL_NONE, SEL_BOTH};
	assign hready = hreadyout;
	pwdm_top i_dut (.clk_sys, .rstn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .demod_pin, .sixteen_bit_timer_out,
		.port3_bit4_pin, .port3_bit5_pin, .port3_bit6_pin, .irq);
	pwdm_pin_src i_src (.clk_sys, .pin(demod_pin));
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// address phase held until hready, then data phase until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		@(posedge clk_sys);
		while (hready !== 1'h1) @(posedge clk_sys);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hready !== 1'h1) @(posedge clk_sys);
		r = hrdata;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// the whole run is a few thousand cycles
	initial begin
		repeat (10000) @(posedge clk_sys);
		fail_count++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{seed, rstn, hsel, haddr, htrans, hwrite, hwdata} = {32'h003B770F, 1'h0, 1'h1, 67'h0};
		{sixteen_bit_timer_out, fail_count, total_checks, cyc} = '0;
		{clk_en, hsize} = {1'h1, 3'h2};
		capv = '{8'h00, 8'h00};
		repeat (3) @(posedge clk_sys);
		rstn <= 1'h1;
		@(posedge clk_sys);
		foreach (RA[i]) begin
			bus(1'h0, RA[i], 32'h0);
			chk(r, {24'h0, RV[i]});
		end
		bus(1'h1, OFS_LOW_LOAD, 32'hFF);
		bus(1'h1, OFS_HIGH_LOAD, 32'hFF);
		bus(1'h1, OFS_IRQ_MASK, 32'h7);
		bus(1'h1, OFS_WIDE_CTRL, 32'h1);
		repeat (4) begin
			c1 = xs();
			sixteen_bit_timer_out <= c1[0];
			repeat (3) @(posedge clk_sys);
			chk(32'(port3_bit5_pin), 32'(c1[0]));
		end
		$display("test reset and routing done");
		foreach (SELS[k]) begin
			s = SELS[k];
			bus(1'h1, OFS_BYTE_CTRL, 32'h1);
			bus(1'h1, OFS_IRQ_STAT, 32'h7);
			bus(1'h1, OFS_SHARED_CTRL, {26'h0, s, 4'h3});
			bus(1'h1, OFS_BYTE_CTRL, 32'h87);
			started = 1'h0;
			fl = 2'h0;
			for (int i = 0; i < 4; i++) begin
				i_src.edge_after(20 + int'(xs() & 32'h7F));
				if (s == SEL_BOTH || s == (i[0] ? SEL_FALL : SEL_RISE)) begin
					if (started) begin
						capv[!i[0]] = 8'(cyc - last - 1);
						fl[!i[0]] = 1'h1;
					end
					started = 1'h1;
					last = cyc;
				end
			end
			repeat (6) @(posedge clk_sys);
			bus(1'h0, OFS_RISE_CAP, 32'h0);
			chk(r, {24'h0, capv[1]});
			bus(1'h0, OFS_FALL_CAP, 32'h0);
			chk(r, {24'h0, capv[0]});
			bus(1'h0, OFS_SHARED_CTRL, 32'h0);
			chk(r, {26'h0, s, 2'h0, fl});
			bus(1'h0, OFS_COUNT, 32'h0);
			if (s == SEL_NONE)
				chk(r, 32'hFF);
			$display("test edge select %0d done", s);
		end
		chk(32'(irq), 32'h1);
		bus(1'h1, OFS_IRQ_MASK, 32'h4);
		repeat (3) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		bus(1'h1, OFS_IRQ_MASK, 32'h7);
		repeat (3) @(posedge clk_sys);
		chk(32'(irq), 32'h1);
		bus(1'h1, OFS_IRQ_STAT, 32'h3);
		repeat (5) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		$display("test interrupt done");
		bus(1'h1, OFS_BYTE_CTRL, 32'h1);
		bus(1'h1, OFS_IRQ_STAT, 32'h7);
		bus(1'h1, OFS_SHARED_CTRL, {26'h0, SEL_RISE, 4'h3});
		bus(1'h1, OFS_BYTE_CTRL, 32'h87);
		i_src.edge_after(5);
		last = cyc;
		repeat (20) @(posedge clk_sys);
		p4a = port3_bit4_pin;
		bus(1'h0, OFS_COUNT, 32'h0);
		c1 = r;
		bus(1'h0, OFS_COUNT, 32'h0);
		chk((c1 - r) & 32'hFF, 32'h2);
		while (cyc < last + 265) @(posedge clk_sys);
		chk(32'(irq), 32'h1);
		chk(32'(port3_bit4_pin), 32'(!p4a));
		chk(32'(port3_bit6_pin), 32'(!p4a));
		bus(1'h0, OFS_BYTE_CTRL, 32'h0);
		chk(r & 32'h20, 32'h20);
		bus(1'h1, OFS_IRQ_STAT, 32'h4);
		while (cyc < last + 450) @(posedge clk_sys);
		bus(1'h0, OFS_IRQ_STAT, 32'h0);
		chk(r & 32'h4, 32'h0);
		while (cyc < last + 530) @(posedge clk_sys);
		bus(1'h0, OFS_IRQ_STAT, 32'h0);
		chk(r & 32'h4, 32'h4);
		chk(32'(port3_bit4_pin), 32'(p4a));
		$display("test timeout done");
		// 16 enabled clk at prescale 3 hold exactly two ticks; frozen clk add none
		bus(1'h1, OFS_BYTE_CTRL, 32'h9F);
		bus(1'h0, OFS_COUNT, 32'h0);
		c1 = r;
		clk_en <= 1'h0;
		repeat (40) @(posedge clk_sys);
		clk_en <= 1'h1;
		repeat (14) @(posedge clk_sys);
		bus(1'h0, OFS_COUNT, 32'h0);
		chk((c1 - r) & 32'hFF, 32'h2);
		$display("test prescale and freeze done");
		end_of_test();
	end
endmodule
`default_nettype wire

// ==== tb/pwdm_chk.sv ====
// Purpose: port checker for pwdm_top
// Assumes: byte route kept set once written
// Notes:   bind follows the module
`timescale 1ns/1ps
`default_nettype none
module pwdm_chk
	import pwdm_pkg::*;
(
	// clock, reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// pins
	input wire logic        sixteen_bit_timer_out,
	input wire logic        port3_bit4_pin,
	input wire logic        port3_bit5_pin,
	input wire logic        port3_bit6_pin,
	input wire logic        irq
);
	logic       take;
	logic       st_wr_q;
	logic       p4_q;
	logic [7:0] gap_q;
	assign take = hsel && hready && htrans[1];
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		st_wr_q <= rstn && take && hwrite && haddr[7:0] == OFS_IRQ_STAT;
	end
	// a timeout needs 255 ticks from all-ones, so bit4 toggles stay far apart
	always_ff @(posedge clk_sys) begin
		p4_q <= rstn && port3_bit4_pin;
		if (!rstn || port3_bit4_pin != p4_q)
			gap_q <= rstn ? 8'h00 : 8'hFF;
		else if (gap_q != 8'hFF)
			gap_q <= gap_q + 8'h01;
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_ready;
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) else $error("bus not ready or not okay");
	property p_hi;
		hrdata[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("read data upper bits set");
	property p_stand;
		!(take && !hwrite) |=> $stable(hrdata);
	endproperty
	a_stand: assert property (p_stand) else $error("read data moved without read");
	property p_clr;
		st_wr_q |-> ##2 !$fell(irq);
	endproperty
	a_clr: assert property (p_clr) else $error("status clear acted at once");
	property p_gap;
		$changed(port3_bit4_pin) |-> gap_q >= 8'd254;
	endproperty
	a_gap: assert property (p_gap) else $error("timeouts too close");
	property p_p5;
		port3_bit5_pin |-> $past(sixteen_bit_timer_out);
	endproperty
	a_p5: assert property (p_p5) else $error("bit5 pin without source");
	property p_rst;
		$rose(rstn) |-> !irq && !port3_bit4_pin && !port3_bit5_pin && !port3_bit6_pin;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	property p_irq0;
		$rose(rstn) |=> !irq;
	endproperty
	a_irq0: assert property (p_irq0) else $error("interrupt right after reset");
endmodule
bind pwdm_top pwdm_chk i_chk (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.hreadyout, .hresp, .sixteen_bit_timer_out, .port3_bit4_pin, .port3_bit5_pin, .port3_bit6_pin, .irq);
`default_nettype wire

// ==== tb/pwdm_pin_src.sv ====
// Purpose: external pulse source on the demodulator pin
// Assumes: caller stands just after a clk_sys edge
// Notes:   push-pull source, always driven
`timescale 1ns/1ps
`default_nettype none
module pwdm_pin_src (
	// clock
	input wire logic clk_sys,
	// pin
	output var logic pin
);
	initial pin = 1'h0;
	// flip after gap edges; returns at that edge
	task automatic edge_after(input int gap);
		repeat (gap) @(posedge clk_sys);
		pin <= ~pin;
	endtask
endmodule
`default_nettype wire
